/* core/srrtc_top.sv */
// SDRAM refresh sequencer and ROM turn-off timer with its register slave
// Functional notes
// - Issue CAS-before-RAS refresh every refresh_interval cycles, field bits 15:2.
// - On expiry send precharge first, then the refresh command.
// - A refresh due during an access waits until that access ends.
// - Close open pages first, two cycles per bank precharge.
// - Wait the precharge-to-activate delay before the refresh command.
// - Wait timer bits 31:29, reset 000, adds waits after ROM accesses.
// - At least two clocks bus release, plus n minus one from timer.
// - Turn-off delay after any ROM access blocks every following access.
// - 8-bit ROM burst read lasts ((fal+2)*8+3)*4+5 cycles, then turn-off.
`timescale 1ns/1ps
`default_nettype none

module srrtc_top
  import srrtc_pkg::*;
(
  input  wire logic               i_clk,             // Memory clock, 200 MHz
  input  wire logic               i_nrst,            // Async reset, active low
  input  wire srrtc_avs_req_type  i_avs,             // Avalon-MM request
  output logic [31:0]             o_avs_readdata,    // Avalon-MM read data
  output logic                    o_avs_waitrequest, // Avalon-MM wait
  input  wire srrtc_acc_req_type  i_acc_req,         // Memory access request
  input  wire logic               i_acc_done,        // Non-timed access finished
  input  wire logic [1:0]         i_open_pages,      // Open SDRAM pages
  output logic                    o_acc_grant,       // Access start, one cycle
  output logic                    o_acc_busy,        // Access in progress
  output logic                    o_rom_turnoff,     // Bus release delay running
  output srrtc_cmd_type           o_sdram_cmd,       // SDRAM command
  output logic                    o_refresh_due,     // Refresh pending
  output srrtc_ecc_cfg_type       o_ecc_cfg          // ECC mode bits
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  // Assert at once, release two edges later
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic [31:0]     cfg_b_r;
  logic [31:0]     timing_r;
  logic            wait_r;
  logic [31:0]     status_word;
  logic [31:0]     read_word;
  logic [13:0]     refresh_count;
  srrtc_state_type state_r;
  logic [3:0]      toff_r;
  logic            busy_r;

  function automatic srrtc_sel_type reg_sel(input logic [8:0] a);
    if (a == REG_CFG_B_OFS)  return SEL_CFG_B;
    if (a == REG_TIMING_OFS) return SEL_TIMING;
    if (a == REG_STATUS_OFS) return SEL_STATUS;
    return SEL_NONE;
  endfunction

  // Byte-lane merge restricted to writable bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = (wd[i*8 +: 8] & mask[i*8 +: 8]) | (old[i*8 +: 8] & ~mask[i*8 +: 8]);
      end
    end
    return res;
  endfunction

  // One wait state per access keeps read data a registered copy
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((i_avs.read || i_avs.write) && wait_r);
    end
  end

  // Status view of the block's own state
  always_comb begin
    status_word                               = '0;
    status_word[STAT_DUE_BIT]                 = o_refresh_due;
    status_word[STAT_TOFF_BIT]                = o_rom_turnoff;
    status_word[STAT_BUSY_BIT]                = busy_r;
    status_word[STAT_CNT_MSB:STAT_CNT_LSB]    = refresh_count;
  end

  // Read mux; reserved bits are never stored, so they read zero
  always_comb begin
    unique case (reg_sel(i_avs.address))
      SEL_CFG_B:  read_word = cfg_b_r;
      SEL_TIMING: read_word = timing_r;
      SEL_STATUS: read_word = status_word;
      SEL_NONE:   read_word = '0;
    endcase
  end

  // Read data captured as wait drops
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_avs_readdata <= '0;
    end else if (i_avs.read && wait_r) begin
      o_avs_readdata <= read_word;
    end
  end

  // Writes land at the edge where wait is sampled low
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_b_r  <= CFG_B_RESET;
      timing_r <= TIMING_RESET;
    end else if (i_avs.write && !wait_r) begin
      if (reg_sel(i_avs.address) == SEL_CFG_B) begin
        cfg_b_r <= merge(cfg_b_r, i_avs.writedata, i_avs.byteenable, CFG_B_WMASK);
      end
      if (reg_sel(i_avs.address) == SEL_TIMING) begin
        timing_r <= merge(timing_r, i_avs.writedata, i_avs.byteenable, TIMING_WMASK);
      end
    end
  end

  assign o_avs_waitrequest = wait_r;

  // ECC mode bits straight from the register; software sets them for ECC use
  // One assignment drives the whole struct, so the output has a single driver
  assign o_ecc_cfg = '{
    inline_parity_select:     cfg_b_r[INLINE_PAR_BIT],
    inline_write_check:       cfg_b_r[INLINE_WR_BIT],
    inline_read_check:        cfg_b_r[INLINE_RD_BIT],
    legacy_correction:        cfg_b_r[LEGACY_ECC_BIT],
    extended_data_out_select: cfg_b_r[EDO_SEL_BIT],
    read_modify_write_parity: cfg_b_r[READ_MODIFY_WRITE_PARITY_BIT]
  };

  // ----------------------------------------------------------------
  // Refresh interval timer
  // ----------------------------------------------------------------
  logic refresh_issue;

  assign refresh_issue = (state_r == ST_REFRESH);

  srrtc_refresh_timer u_refresh_timer (
    .i_clk      (i_clk),
    .i_rst_n    (rst_n_r),
    .i_interval (cfg_b_r[REFRESH_INTERVAL_MSB:REFRESH_INTERVAL_LSB]),
    .i_reload   (refresh_issue),
    .o_due      (o_refresh_due),
    .o_count    (refresh_count)
  );

  // ----------------------------------------------------------------
  // Access and refresh sequencer
  // ----------------------------------------------------------------
  logic [11:0] cnt_r;
  logic        burst_r;
  logic        cur_rom_r;
  logic        go_refresh;
  logic        go_access;
  logic        access_done;
  logic [3:0]  precharge_to_activate_delay;
  logic [3:0]  toff_nxt;

  assign precharge_to_activate_delay    = timing_r[PRECHARGE_TO_ACTIVATE_DELAY_MSB:PRECHARGE_TO_ACTIVATE_DELAY_LSB];
  // Refresh outranks a new access, but never cuts into one or into turn-off
  assign go_refresh  = (state_r == ST_IDLE) && o_refresh_due && (toff_r == 4'h0);
  assign go_access   = (state_r == ST_IDLE) && !o_refresh_due && (toff_r == 4'h0)
                       && i_acc_req.valid;
  assign access_done = (state_r == ST_ACCESS)
                       && (burst_r ? (cnt_r == 12'h000) : i_acc_done);

  // Main sequence: precharge banks, wait, refresh; or run one access
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r     <= ST_IDLE;
      cnt_r       <= '0;
      burst_r     <= 1'b0;
      cur_rom_r   <= 1'b0;
      o_sdram_cmd <= CMD_NOP;
      o_acc_grant <= 1'b0;
    end else begin
      o_acc_grant <= 1'b0;
      o_sdram_cmd <= CMD_NOP;
      unique case (state_r)
        ST_IDLE: begin
          if (go_refresh) begin
            state_r     <= ST_PRECHARGE;
            o_sdram_cmd <= CMD_PRECHARGE;
            // Always at least one precharge; two open pages cost four cycles
            cnt_r <= {10'h000, (i_open_pages[1] ? PRE_CNT_TWO_BANK : PRE_CNT_ONE_BANK)};
          end else if (go_access) begin
            state_r     <= ST_ACCESS;
            o_acc_grant <= 1'b1;
            burst_r     <= i_acc_req.burst8;
            cur_rom_r   <= i_acc_req.rom;
            cnt_r <= rom_burst_cycles(timing_r[ROM_FIRST_ACCESS_LATENCY_MSB:ROM_FIRST_ACCESS_LATENCY_LSB]) - 12'h001;
          end
        end
        ST_ACCESS: begin
          if (access_done) begin
            state_r <= ST_IDLE;
          end else if (burst_r) begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        ST_PRECHARGE: begin
          if (cnt_r == 12'h000) begin
            state_r <= ST_PRE_WAIT;
            cnt_r   <= {8'h00, precharge_to_activate_delay};
          end else begin
            cnt_r <= cnt_r - 12'h001;
            // Second bank's precharge opens its own two-cycle slot
            if (cnt_r == 12'h002) begin
              o_sdram_cmd <= CMD_PRECHARGE;
            end
          end
        end
        ST_PRE_WAIT: begin
          if (cnt_r <= 12'h001) begin
            state_r     <= ST_REFRESH;
            o_sdram_cmd <= CMD_REFRESH;
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        ST_REFRESH: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Busy flag mirrors the access window
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      busy_r <= 1'b0;
    end else if (go_access) begin
      busy_r <= 1'b1;
    end else if (access_done) begin
      busy_r <= 1'b0;
    end
  end

  assign o_acc_busy = busy_r;

  // ----------------------------------------------------------------
  // ROM turn-off timer
  // ----------------------------------------------------------------
  // Loaded at the end of every ROM access, counted down while idle
  always_comb begin
    if (access_done && cur_rom_r) begin
      toff_nxt = turnoff_cycles(cfg_b_r[TOFF_WAIT_MSB:TOFF_WAIT_LSB]);
    end else if (toff_r != 4'h0) begin
      toff_nxt = toff_r - 4'h1;
    end else begin
      toff_nxt = 4'h0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      toff_r        <= 4'h0;
      o_rom_turnoff <= 1'b0;
    end else begin
      toff_r        <= toff_nxt;
      o_rom_turnoff <= (toff_nxt != 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic        saw_pre_r;
  logic [4:0]  pw_cnt_r;
  logic [11:0] acc_len_r;

  // Helpers: precharge seen, cycles in delay wait, cycles in access
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      saw_pre_r <= 1'b0;
      pw_cnt_r  <= '0;
      acc_len_r <= '0;
    end else begin
      saw_pre_r <= (o_sdram_cmd == CMD_PRECHARGE) || (saw_pre_r && o_sdram_cmd != CMD_REFRESH);
      pw_cnt_r  <= (state_r == ST_PRE_WAIT) ? pw_cnt_r + 5'h01 : 5'h00;
      acc_len_r <= (state_r == ST_ACCESS) ? acc_len_r + 12'h001 : 12'h000;
    end
  end

  property p_pre_before_ref;
    @(posedge i_clk) disable iff (!rst_n_r)
    (o_sdram_cmd == CMD_REFRESH) |-> saw_pre_r;
  endproperty
  a_pre_before_ref: assert property (p_pre_before_ref)
    else $error("refresh issued without a preceding precharge");

  property p_refresh_waits;
    @(posedge i_clk) disable iff (!rst_n_r)
    (state_r == ST_ACCESS && !access_done) |=> (state_r == ST_ACCESS)
      && (o_sdram_cmd == CMD_NOP);
  endproperty
  a_refresh_waits: assert property (p_refresh_waits)
    else $error("access cut short");

  property p_two_bank_pre;
    @(posedge i_clk) disable iff (!rst_n_r)
    (go_refresh && i_open_pages[1])
      |=> (o_sdram_cmd == CMD_PRECHARGE) ##2 (o_sdram_cmd == CMD_PRECHARGE)
          ##2 (state_r == ST_PRE_WAIT);
  endproperty
  a_two_bank_pre: assert property (p_two_bank_pre)
    else $error("two-page precharge not spread over four cycles");

  property p_precharge_to_activate_delay;
    @(posedge i_clk) disable iff (!rst_n_r)
    (o_sdram_cmd == CMD_REFRESH) |-> ({1'b0, precharge_to_activate_delay} <= pw_cnt_r) && $past(state_r == ST_PRE_WAIT);
  endproperty
  a_precharge_to_activate_delay: assert property (p_precharge_to_activate_delay)
    else $error("refresh before precharge-to-activate delay");

  property p_turnoff_len;
    @(posedge i_clk) disable iff (!rst_n_r)
    (access_done && cur_rom_r && cfg_b_r[TOFF_WAIT_MSB:TOFF_WAIT_LSB] == 3'h0)
      |=> o_rom_turnoff [*2] ##1 !o_rom_turnoff;
  endproperty
  a_turnoff_len: assert property (p_turnoff_len)
    else $error("minimum bus release not two clocks");

  property p_turnoff_timer;
    @(posedge i_clk) disable iff (!rst_n_r)
    (access_done && cur_rom_r)
      |=> (toff_r == TOFF_MIN_CYC + {1'b0, $past(cfg_b_r[TOFF_WAIT_MSB:TOFF_WAIT_LSB])} - 4'h1)
          || ($past(cfg_b_r[TOFF_WAIT_MSB:TOFF_WAIT_LSB]) == 3'h0);
  endproperty
  a_turnoff_timer: assert property (p_turnoff_timer)
    else $error("turn-off timer loaded with wrong count");

  property p_no_grant_in_turnoff;
    @(posedge i_clk) disable iff (!rst_n_r)
    o_rom_turnoff |=> !o_acc_grant && (o_sdram_cmd != CMD_PRECHARGE);
  endproperty
  a_no_grant_in_turnoff: assert property (p_no_grant_in_turnoff)
    else $error("access started during ROM turn-off");

  property p_burst_len;
    @(posedge i_clk) disable iff (!rst_n_r)
    (access_done && burst_r)
      |-> (acc_len_r == rom_burst_cycles(timing_r[ROM_FIRST_ACCESS_LATENCY_MSB:ROM_FIRST_ACCESS_LATENCY_LSB]) - 12'h001);
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("8-bit ROM burst has wrong length");

endmodule

`default_nettype wire

/* include/srrtc_pkg.sv */
// Shared constants, types and helpers of the SDRAM refresh and ROM turn-off controller
package srrtc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [8:0]  REG_CFG_B_OFS    = 9'h0F4;
  localparam logic [8:0]  REG_TIMING_OFS   = 9'h0F8;
  localparam logic [8:0]  REG_STATUS_OFS   = 9'h0FC;

  // ----------------------------------------------------------------
  // memory_control_config_b fields
  // ----------------------------------------------------------------
  localparam int          TOFF_WAIT_MSB    = 31;
  localparam int          TOFF_WAIT_LSB    = 29;
  localparam int          INLINE_PAR_BIT   = 20;
  localparam int          INLINE_WR_BIT    = 19;
  localparam int          INLINE_RD_BIT    = 18;
  localparam int          LEGACY_ECC_BIT   = 17;
  localparam int          EDO_SEL_BIT      = 16;
  localparam int          REFRESH_INTERVAL_MSB       = 15;
  localparam int          REFRESH_INTERVAL_LSB       = 2;
  localparam int          READ_MODIFY_WRITE_PARITY_BIT      = 0;
  localparam logic [31:0] CFG_B_RESET      = 32'h0000_0000;
  localparam logic [31:0] CFG_B_WMASK      = 32'hE01F_FFFD;

  // ----------------------------------------------------------------
  // Timing register fields
  // ----------------------------------------------------------------
  localparam int          ROM_FIRST_ACCESS_LATENCY_MSB       = 4;
  localparam int          ROM_FIRST_ACCESS_LATENCY_LSB       = 0;
  localparam int          PRECHARGE_TO_ACTIVATE_DELAY_MSB     = 11;
  localparam int          PRECHARGE_TO_ACTIVATE_DELAY_LSB     = 8;
  localparam logic [31:0] TIMING_RESET     = 32'h0000_0000;
  localparam logic [31:0] TIMING_WMASK     = 32'h0000_0F1F;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int          STAT_DUE_BIT     = 0;
  localparam int          STAT_TOFF_BIT    = 1;
  localparam int          STAT_BUSY_BIT    = 2;
  localparam int          STAT_CNT_LSB     = 16;
  localparam int          STAT_CNT_MSB     = 29;

  // ----------------------------------------------------------------
  // Timing counts in memory clocks
  // ----------------------------------------------------------------
  localparam logic [3:0]  TOFF_MIN_CYC     = 4'h2;
  localparam logic [11:0] ROM8_LAT_ADD     = 12'h002;
  localparam logic [11:0] ROM8_BEATS       = 12'h008;
  localparam logic [11:0] ROM8_BEAT_ADD    = 12'h003;
  localparam logic [11:0] ROM8_BURST       = 12'h004;
  localparam logic [11:0] ROM8_TAIL        = 12'h005;
  localparam logic [1:0]  PRE_CNT_ONE_BANK = 2'h1;
  localparam logic [1:0]  PRE_CNT_TWO_BANK = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CMD_NOP, CMD_PRECHARGE, CMD_REFRESH} srrtc_cmd_type;
  typedef enum logic [2:0] {ST_IDLE, ST_ACCESS, ST_PRECHARGE, ST_PRE_WAIT,
                            ST_REFRESH} srrtc_state_type;
  typedef enum logic [1:0] {SEL_NONE, SEL_CFG_B, SEL_TIMING, SEL_STATUS} srrtc_sel_type;

  typedef struct packed {
    logic [8:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } srrtc_avs_req_type;

  typedef struct packed {
    logic valid;   // Access waiting for a grant
    logic rom;     // ROM, Flash or Port X access
    logic burst8;  // Burst read from an 8-bit ROM
  } srrtc_acc_req_type;

  typedef struct packed {
    logic inline_parity_select;
    logic inline_write_check;
    logic inline_read_check;
    logic legacy_correction;
    logic extended_data_out_select;
    logic read_modify_write_parity;
  } srrtc_ecc_cfg_type;

  // Length of a burst read from an 8-bit ROM
  function automatic logic [11:0] rom_burst_cycles(input logic [4:0] fal);
    logic [11:0] f;
    f = {7'h00, fal};
    return ((f + ROM8_LAT_ADD) * ROM8_BEATS + ROM8_BEAT_ADD) * ROM8_BURST + ROM8_TAIL;
  endfunction

  // Bus release time after a ROM access; a zero field gives the minimum
  function automatic logic [3:0] turnoff_cycles(input logic [2:0] w);
    return (w == 3'h0) ? TOFF_MIN_CYC : TOFF_MIN_CYC + {1'b0, w} - 4'h1;
  endfunction

endpackage

/* core/srrtc_refresh_timer.sv */
// Refresh interval down-counter with sticky due flag
`timescale 1ns/1ps
`default_nettype none

module srrtc_refresh_timer
  import srrtc_pkg::*;
(
  input  wire logic        i_clk,       // Memory clock
  input  wire logic        i_rst_n,     // Synchronised reset, active low
  input  wire logic [13:0] i_interval,  // Programmed refresh interval
  input  wire logic        i_reload,    // Refresh command issued
  output logic             o_due,       // Refresh falls due
  output logic [13:0]      o_count      // Cycles left in interval
);

  // ----------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------
  // Reload on each refresh, then count down and park at zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= '0;
    end else if (i_reload) begin
      o_count <= i_interval;
    end else if (o_count != 14'h0000) begin
      o_count <= o_count - 14'h0001;
    end
  end

  // Due flag: set while the count sits at zero, cleared by the refresh that reloads it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_due <= 1'b0;
    end else if (o_count == 14'h0000 && !i_reload) begin
      o_due <= 1'b1;
    end else if (i_reload) begin
      o_due <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_due_on_expiry;
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_count == 14'h0000 && !i_reload) |=> o_due;
  endproperty
  a_due_on_expiry: assert property (p_due_on_expiry)
    else $error("refresh not due after interval expired");

  property p_reload;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_reload |=> (o_count == $past(i_interval)) && !o_due;
  endproperty
  a_reload: assert property (p_reload)
    else $error("refresh counter not reloaded after refresh");

endmodule

`default_nettype wire

/* bench/srrtc_mem_model.sv */
// Memory-bus partner: access completion pulses and bus-order watch
`timescale 1ns/1ps
`default_nettype none
module srrtc_mem_model
  import srrtc_pkg::*;
(
  input  wire logic          i_clk,     // Memory clock
  input  wire logic          i_grant,   // Access started
  input  wire logic          i_busy,    // Access running
  input  wire logic          i_turnoff, // ROM bus release running
  input  wire srrtc_cmd_type i_cmd,     // SDRAM command
  input  wire logic [3:0]    i_delay,   // Cycles to finish, prompt or slow
  output logic               o_done,    // Access finished pulse
  output logic [7:0]         o_bad      // Order faults seen
);
  logic [3:0] cnt_r;
  logic       pre_r;
  initial begin
    o_done = 1'b0;
    o_bad = 8'h00;
    cnt_r = 4'h0;
    pre_r = 1'b0;
  end
  // ----------------------------------------
  // Completion and order watch
  // ----------------------------------------
  // Only one fault counted per cycle, enough to flag a broken order
  always @(posedge i_clk) begin
    o_done <= (cnt_r == 4'h1);
    if (i_grant) cnt_r <= i_delay + 4'h1;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    if (i_cmd == CMD_PRECHARGE) pre_r <= 1'b1;
    if (i_cmd == CMD_REFRESH) pre_r <= 1'b0;
    if ((i_cmd == CMD_REFRESH && !pre_r) ||
        (i_cmd != CMD_NOP && (i_busy || i_turnoff)) ||
        (i_grant && i_turnoff)) o_bad <= o_bad + 8'h01;
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Testbench: register access, refresh sequencing and ROM turn-off timing
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srrtc_pkg::*;
  logic i_clk, i_nrst, done, wq, busy, toff, grant, due;
  logic [31:0] rdata, q;
  logic [1:0] pages;
  logic [3:0] dly;
  logic [7:0] bad;
  srrtc_avs_req_type avs;
  srrtc_acc_req_type acc;
  srrtc_cmd_type cmd;
  srrtc_ecc_cfg_type ecc;
  int n_mismatch, samples_checked, g, t;
  srrtc_top srrtc_top_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs(avs),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .i_acc_req(acc), .i_acc_done(done),
    .i_open_pages(pages), .o_acc_grant(grant), .o_acc_busy(busy), .o_rom_turnoff(toff),
    .o_sdram_cmd(cmd), .o_refresh_due(due), .o_ecc_cfg(ecc));
  srrtc_mem_model srrtc_mem_model_inst (.i_clk(i_clk), .i_grant(grant), .i_busy(busy),
    .i_turnoff(toff), .i_cmd(cmd), .i_delay(dly), .o_done(done), .o_bad(bad));
  // ----------------------------------------
  // Clock, checks and bus tasks
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
    avs <= '{a, !wr, wr, d, 4'hF};
    @(posedge i_clk);
    while (wq !== 1'b0) @(posedge i_clk);
    q = rdata;
    avs <= '0;
    @(posedge i_clk);
  endtask
  // Counts busy cycles, then turn-off cycles; nxt raises a new request during turn-off
  task automatic access(input logic rom, input logic b8, input logic nxt,
                        output int nb, output int nt);
    acc <= '{1'b1, rom, b8};
    @(posedge i_clk);
    while (grant !== 1'b1) @(posedge i_clk);
    acc <= '0;
    nb = 0;
    nt = 0;
    while (busy === 1'b1) begin nb++; @(posedge i_clk); end
    if (nxt) acc <= '{1'b1, 1'b0, 1'b0};
    while (toff === 1'b1) begin nt++; @(posedge i_clk); end
  endtask
  // Cycles from precharge to refresh command
  task automatic refgap(output int n);
    while (cmd !== CMD_PRECHARGE) @(posedge i_clk);
    n = 0;
    while (cmd !== CMD_REFRESH) begin n++; @(posedge i_clk); end
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    i_nrst = 1'b0;
    avs = '0;
    acc = '0;
    pages = 2'h1;
    dly = 4'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    bus(0, REG_CFG_B_OFS, 0); chk(q, 32'h0);
    bus(1, REG_CFG_B_OFS, 32'hFFFF_FFFF);
    bus(0, REG_CFG_B_OFS, 0); chk(q, CFG_B_WMASK);
    chk(ecc, 32'h3F);
    bus(1, REG_CFG_B_OFS, 32'h6004_0321);
    chk(ecc, 32'h09);
    bus(1, 9'h0F0, 32'hFFFF_FFFF);
    bus(0, 9'h0F0, 0); chk(q, 32'h0);
    bus(0, REG_CFG_B_OFS, 0); chk(q, 32'h6004_0321);
    bus(1, REG_TIMING_OFS, 32'h0000_0301);
    refgap(g); refgap(g); chk(g, 5);
    pages <= 2'h2;
    refgap(g); refgap(g); chk(g, 7);
    t = 0;
    while (due !== 1'b0) begin t++; @(posedge i_clk); end
    while (due !== 1'b1) begin t++; @(posedge i_clk); end
    chk(t, 202);
    access(1, 1, 1, g, t); chk(g, 113); chk(t, 4);
    access(0, 0, 0, g, t); chk(t, 0);
    bus(1, REG_CFG_B_OFS, 32'h0004_0321);
    dly <= 4'h9;
    access(1, 0, 0, g, t); chk(t, 2);
    access(1, 1, 0, g, t); chk(t, 2);
    repeat (300) @(posedge i_clk);
    bus(0, REG_STATUS_OFS, 0); chk(q & 32'hC000_FFFE, 32'h0);
    chk(bad, 32'h0);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
